/* File: src/rcmi_pkg.sv */
// Purpose: Shared constants and types for the reset, clock and memory-test infrastructure.
// Assumes: One system clock; register words are 32 bits.
// Notes: Device register offsets and host controller offsets both live here.
package rcmi_pkg;
  ////////////////////////////////////////////////////////////////////////////
  localparam int REG_AW = 8;
  localparam int DW = 32;
  localparam int SYNC_W = 2;
  // Device register offsets
  localparam logic [REG_AW-1:0] OFF_MODE = 8'h00;
  localparam logic [REG_AW-1:0] OFF_STAT = 8'h04;
  localparam logic [REG_AW-1:0] OFF_TCTL = 8'h08;
  localparam logic [REG_AW-1:0] OFF_DEST = 8'h0C;
  localparam logic [REG_AW-1:0] OFF_WDAT = 8'h10;
  localparam logic [REG_AW-1:0] OFF_RDAT = 8'h14;
  // Device field positions
  localparam int MODE_SRST = 0;
  localparam int MODE_TEST_MODE_BIT = 1;
  localparam int STAT_RXBIT = 0;
  localparam int STAT_PAR = 1;
  localparam int STAT_TACC = 2;
  localparam int TCTL_MEMORY_TEST_ENABLE = 0;
  localparam int TCTL_WRSTB = 1;
  localparam int DEST_ADDR_LSB = 0;
  localparam int DEST_ADDR_W = 12;
  localparam int DEST_TGT_LSB = 16;
  localparam int TGT_W = 2;
  localparam int DEST_PAR = 31;
  localparam logic [DW-1:0] DEST_MASK = 32'h8003_0FFF;
  localparam logic [TGT_W-1:0] TGT_RX = 2'h0;
  // Memories
  localparam int RX_DEPTH = 128;
  localparam int RX_AW = 7;
  localparam int TXT_DEPTH = 20;
  localparam int TXT_AW = 5;
  localparam int TXT_COUNT = 2;
  localparam int MEM_W = 33;
  // Technology and line levels
  localparam bit TARGET_ASIC = 1'b0;
  localparam bit TARGET_FPGA = 1'b1;
  localparam logic CAN_RECESSIVE = 1'b1;
  ////////////////////////////////////////////////////////////////////////////
  // Host controller offsets and fields
  localparam logic [REG_AW-1:0] H_CTRL = 8'h00;
  localparam logic [REG_AW-1:0] H_CMD = 8'h04;
  localparam logic [REG_AW-1:0] H_WDAT = 8'h08;
  localparam logic [REG_AW-1:0] H_RDAT = 8'h0C;
  localparam logic [REG_AW-1:0] H_STAT = 8'h10;
  localparam int HCTRL_RST = 0;
  localparam int HCMD_ADDR_LSB = 0;
  localparam int HCMD_WRITE = 8;
  localparam int HSTAT_BUSY = 0;
  localparam int HSTAT_READY = 1;
  localparam int HSTAT_DONE = 2;
  typedef enum logic [1:0] {
    RCMI_IDLE = 2'b00,
    RCMI_WAIT_RDY = 2'b01,
    RCMI_ISSUE = 2'b10,
    RCMI_WAIT_RD = 2'b11
  } rcmi_hstate_t;
endpackage

/* File: src/rcmi_if.sv */
// Purpose: Link between the system reset controller / bus bridge and the device.
// Assumes: clk is the single system clock shared by both ends.
// Notes: Register read data answers one cycle after the read pulse.
interface rcmi_if (
  input wire logic clk // System clock
);
  logic ext_res_n;
  logic res_n_out;
  logic reg_wr;
  logic reg_rd;
  logic [rcmi_pkg::REG_AW-1:0] reg_addr;
  logic [rcmi_pkg::DW-1:0] reg_wdata;
  logic [rcmi_pkg::DW-1:0] reg_rdata;
  logic reg_rvalid;
  modport dev (
    input clk, ext_res_n, reg_wr, reg_rd, reg_addr, reg_wdata,
    output res_n_out, reg_rdata, reg_rvalid
  );
  modport host (
    input clk, res_n_out, reg_rdata, reg_rvalid,
    output ext_res_n, reg_wr, reg_rd, reg_addr, reg_wdata
  );
endinterface

/* File: src/rcmi_device.sv */
// Purpose: Reset merge, clock gating and memory-test access of the controller core.
// Assumes: Link register strobes are one-cycle pulses synchronous to clk.
// Notes: Test RAM writes land on gated clocks one cycle after the strobe.
//
// Notes on behaviour
// - pin or soft reset makes one system reset
// - soft reset pipelined by flop without reset
// - host waits two clocks after reset release
// - reset asserts async, releases on running clock
// - writing one to soft-reset bit resets
// - single clock domain, slow timing by enables
// - ASIC target gates RAM clocks, FPGA never
// - ASIC gate latch plus AND; FPGA passes
// - gated core ignores bus, transmits recessive
// - test access exists only if built in
// - test registers ignored outside test mode
// - memory test needs its enable bit set
// - write strobe stores data at destination
// - test read word valid one cycle later
// - any pattern, any address, each memory
// - test access bypasses parity encoding
// - scan opens gates, blocks derived resets
// - rising edge, async reset; RAM flops and soft_q none
// - synchronisers for reset and receive stream
// - synchronised reset output provided
//
// Register access over APB and the placing of the registers are this design's own decisions.

////////////////////////////////////////////////////////////////////////////////
module rcmi_clk_gate import rcmi_pkg::*; #(
  parameter bit TARGET = TARGET_FPGA
) (
  input wire logic clk_in, // Free-running clock
  input wire logic enable, // Clock request
  input wire logic scan_en, // Scan mode
  output wire logic clk_out // Gated clock
);
  generate
    if (TARGET == TARGET_ASIC)
    begin : g_asic
      logic en_lat;
      // Transparent while clock low so the AND never glitches; swap for an ICG cell
      always_latch
      begin
        if (!clk_in)
        begin
          en_lat <= enable | scan_en;
        end
      end
      assign clk_out = clk_in & en_lat;
    end
    else
    begin : g_fpga
      assign clk_out = clk_in;
    end
  endgenerate
endmodule // rcmi_clk_gate

////////////////////////////////////////////////////////////////////////////////
module rcmi_device import rcmi_pkg::*; #(
  parameter bit TARGET_TECH = TARGET_FPGA,
  parameter bit TEST_REGS_EN = 1'b1
) (
  rcmi_if.dev link, // Reset and register link
  input wire logic scan_enable, // Scan mode
  input wire logic can_rx, // Asynchronous bus receive
  output logic can_tx, // Bus transmit
  output logic rx_bit // Synchronised receive bit
);
  logic [SYNC_W-1:0] rst_sync;
  logic soft_req;
  logic soft_q;
  logic sys_rst_n;
  logic test_mode;
  logic memory_test_enable;
  logic [DW-1:0] dest;
  logic [DW-1:0] wword;
  logic [DW-1:0] rword;
  logic rpar;
  logic rx_meta;
  logic test_acc;
  logic mem_we;
  logic wr_pend;
  logic [TGT_W-1:0] wr_tgt;
  logic [DEST_ADDR_W-1:0] wr_addr;
  logic [MEM_W-1:0] wr_word;
  logic [TGT_W-1:0] dest_tgt;
  logic [DEST_ADDR_W-1:0] dest_addr;
  logic [MEM_W-1:0] rx_rd;
  logic [MEM_W-1:0] txt_rd [TXT_COUNT];
  logic [MEM_W-1:0] next_rd;
  logic [DW-1:0] next_rdata;
  logic rx_clk;
  logic [MEM_W-1:0] rx_mem [RX_DEPTH];

  ////////////////////////////////////////////////////////////////////////////
  // Reset structure
  // Asserts without clock, releases after two rising edges
  always_ff @(posedge link.clk or negedge link.ext_res_n)
  begin
    if (!link.ext_res_n)
    begin
      rst_sync <= '0;
    end
    else
    begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign link.res_n_out = rst_sync[SYNC_W-1];

  assign soft_req = link.reg_wr && (link.reg_addr == OFF_MODE) && link.reg_wdata[MODE_SRST];

  // No reset here: its output clears everything, including itself otherwise
  always_ff @(posedge link.clk)
  begin
    soft_q <= soft_req;
  end

  // Soft reset is flop-derived, so scan mode blocks it
  assign sys_rst_n = rst_sync[SYNC_W-1] & (scan_enable | ~soft_q);

  ////////////////////////////////////////////////////////////////////////////
  // Bus-side synchronisers and transmit
  always_ff @(posedge link.clk or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      rx_meta <= CAN_RECESSIVE;
      rx_bit <= CAN_RECESSIVE;
    end
    else
    begin
      rx_meta <= can_rx;
      rx_bit <= rx_meta;
    end
  end

  // No datapath here; a stopped clock freezes this at recessive
  always_ff @(posedge link.clk or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      can_tx <= CAN_RECESSIVE;
    end
    else
    begin
      can_tx <= CAN_RECESSIVE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers, all on the one clock
  assign test_acc = TEST_REGS_EN && test_mode;
  assign dest_tgt = dest[DEST_TGT_LSB +: TGT_W];
  assign dest_addr = dest[DEST_ADDR_LSB +: DEST_ADDR_W];

  always_ff @(posedge link.clk or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      test_mode <= 1'b0;
    end
    else if (link.reg_wr && link.reg_addr == OFF_MODE)
    begin
      test_mode <= link.reg_wdata[MODE_TEST_MODE_BIT];
    end
  end

  always_ff @(posedge link.clk or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      memory_test_enable <= 1'b0;
      dest <= '0;
      wword <= '0;
    end
    else if (link.reg_wr && test_acc)
    begin
      if (link.reg_addr == OFF_TCTL)
      begin
        memory_test_enable <= link.reg_wdata[TCTL_MEMORY_TEST_ENABLE];
      end
      if (link.reg_addr == OFF_DEST)
      begin
        dest <= link.reg_wdata & DEST_MASK;
      end
      if (link.reg_addr == OFF_WDAT)
      begin
        wword <= link.reg_wdata;
      end
    end
  end

  // Strobe counts only with the enable held in both the stored and written value
  assign mem_we = link.reg_wr && test_acc && (link.reg_addr == OFF_TCTL) && memory_test_enable
    && link.reg_wdata[TCTL_MEMORY_TEST_ENABLE] && link.reg_wdata[TCTL_WRSTB];

  always_ff @(posedge link.clk or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      wr_pend <= 1'b0;
      wr_tgt <= '0;
      wr_addr <= '0;
      wr_word <= '0;
    end
    else
    begin
      wr_pend <= mem_we;
      if (mem_we)
      begin
        wr_tgt <= dest_tgt;
        wr_addr <= dest_addr;
        wr_word <= {dest[DEST_PAR], wword}; // Raw parity bit, no encoder
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffer RAMs on gated clocks; plain flops, no reset
  rcmi_clk_gate #(.TARGET(TARGET_TECH)) u_rx_gate (
    .clk_in(link.clk),
    .enable(wr_pend && wr_tgt == TGT_RX),
    .scan_en(scan_enable),
    .clk_out(rx_clk)
  );

  always_ff @(posedge rx_clk)
  begin
    if (wr_pend && wr_tgt == TGT_RX)
    begin
      rx_mem[wr_addr[RX_AW-1:0]] <= wr_word;
    end
  end
  assign rx_rd = rx_mem[dest_addr[RX_AW-1:0]];

  generate
    for (genvar g = 0; g < TXT_COUNT; g++)
    begin : g_txt
      logic txt_clk;
      logic txt_we;
      logic [MEM_W-1:0] mem [TXT_DEPTH];
      assign txt_we = wr_pend && (wr_tgt == TGT_W'(g + 1)) && (wr_addr < DEST_ADDR_W'(TXT_DEPTH));
      rcmi_clk_gate #(.TARGET(TARGET_TECH)) u_gate (
        .clk_in(link.clk),
        .enable(txt_we),
        .scan_en(scan_enable),
        .clk_out(txt_clk)
      );
      always_ff @(posedge txt_clk)
      begin
        if (txt_we)
        begin
          mem[wr_addr[TXT_AW-1:0]] <= wr_word;
        end
      end
      // Out-of-range words read zero rather than index past the array
      assign txt_rd[g] = (dest_addr < DEST_ADDR_W'(TXT_DEPTH)) ? mem[dest_addr[TXT_AW-1:0]] : '0;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read side: RAM word registered once, reads return old data on collision
  always_comb
  begin
    next_rd = '0;
    if (dest_tgt == TGT_RX)
    begin
      next_rd = rx_rd;
    end
    for (int i = 0; i < TXT_COUNT; i++)
    begin
      if (dest_tgt == TGT_W'(i + 1))
      begin
        next_rd = txt_rd[i];
      end
    end
  end

  always_ff @(posedge link.clk or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      rword <= '0;
      rpar <= 1'b0;
    end
    else
    begin
      {rpar, rword} <= next_rd;
    end
  end

  always_comb
  begin
    next_rdata = '0;
    case (link.reg_addr)
      OFF_MODE: next_rdata[MODE_TEST_MODE_BIT] = test_mode;
      OFF_STAT:
      begin
        next_rdata[STAT_RXBIT] = rx_bit;
        next_rdata[STAT_PAR] = rpar & test_acc;
        next_rdata[STAT_TACC] = test_acc;
      end
      OFF_TCTL: next_rdata[TCTL_MEMORY_TEST_ENABLE] = memory_test_enable & test_acc;
      OFF_DEST: next_rdata = test_acc ? dest : '0;
      OFF_WDAT: next_rdata = test_acc ? wword : '0;
      OFF_RDAT: next_rdata = test_acc ? rword : '0;
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge link.clk or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      link.reg_rdata <= '0;
      link.reg_rvalid <= 1'b0;
    end
    else
    begin
      link.reg_rvalid <= link.reg_rd;
      if (link.reg_rd)
      begin
        link.reg_rdata <= next_rdata;
      end
    end
  end
endmodule // rcmi_device

/* File: src/rcmi_host.sv */
// Purpose: Reset controller and APB-driven bridge issuing device register accesses.
// Assumes: Zero-wait APB slave; device answers reads one cycle after the pulse.
// Notes: Commands are held back until the device reports reset complete.
module rcmi_host import rcmi_pkg::*; (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [REG_AW-1:0] paddr, // APB address
  input wire logic [DW-1:0] pwdata, // APB write data
  output logic [DW-1:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped
  rcmi_if.host link // Device link
);
  rcmi_hstate_t state;
  logic ctrl_rst;
  logic [REG_AW-1:0] cmd_addr;
  logic cmd_write;
  logic [DW-1:0] wdat;
  logic [DW-1:0] rdat;
  logic done;
  logic wr_acc;
  logic setup;
  logic cmd_go;
  logic done_set;
  logic [DW-1:0] next_prdata;
  logic next_err;

  ////////////////////////////////////////////////////////////////////////////
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pready && pwrite;
  assign cmd_go = wr_acc && paddr == H_CMD && state == RCMI_IDLE;
  assign done_set = (state == RCMI_ISSUE && cmd_write) || (state == RCMI_WAIT_RD && link.reg_rvalid);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_rst <= 1'b0;
      wdat <= '0;
      link.ext_res_n <= 1'b0;
    end
    else
    begin
      if (wr_acc && paddr == H_CTRL)
      begin
        ctrl_rst <= pwdata[HCTRL_RST];
      end
      if (wr_acc && paddr == H_WDAT)
      begin
        wdat <= pwdata;
      end
      link.ext_res_n <= ~ctrl_rst;
    end
  end

  // Sticky done: a new completion beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done <= 1'b0;
    end
    else if (done_set)
    begin
      done <= 1'b1;
    end
    else if (wr_acc && paddr == H_STAT && pwdata[HSTAT_DONE])
    begin
      done <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= RCMI_IDLE;
      cmd_addr <= '0;
      cmd_write <= 1'b0;
      rdat <= '0;
      link.reg_wr <= 1'b0;
      link.reg_rd <= 1'b0;
      link.reg_addr <= '0;
      link.reg_wdata <= '0;
    end
    else
    begin
      link.reg_wr <= 1'b0;
      link.reg_rd <= 1'b0;
      case (state)
        RCMI_IDLE:
        begin
          if (cmd_go)
          begin
            cmd_addr <= pwdata[HCMD_ADDR_LSB +: REG_AW];
            cmd_write <= pwdata[HCMD_WRITE];
            state <= RCMI_WAIT_RDY;
          end
        end
        RCMI_WAIT_RDY:
        begin
          // Synchronised reset output high covers the two-clock hold-off
          if (link.res_n_out && link.ext_res_n && !ctrl_rst)
          begin
            link.reg_addr <= cmd_addr;
            link.reg_wdata <= wdat;
            link.reg_wr <= cmd_write;
            link.reg_rd <= ~cmd_write;
            state <= RCMI_ISSUE;
          end
        end
        RCMI_ISSUE:
        begin
          state <= cmd_write ? RCMI_IDLE : RCMI_WAIT_RD;
        end
        RCMI_WAIT_RD:
        begin
          if (link.reg_rvalid)
          begin
            rdat <= link.reg_rdata;
            state <= RCMI_IDLE;
          end
          else if (!link.res_n_out)
          begin
            state <= RCMI_IDLE;
          end
        end
        default: state <= RCMI_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer registered in the setup cycle
  always_comb
  begin
    next_prdata = '0;
    next_err = 1'b0;
    case (paddr)
      H_CTRL: next_prdata[HCTRL_RST] = ctrl_rst;
      H_CMD: next_prdata = {{(DW - HCMD_WRITE - 1){1'b0}}, cmd_write, cmd_addr};
      H_WDAT: next_prdata = wdat;
      H_RDAT: next_prdata = rdat;
      H_STAT:
      begin
        next_prdata[HSTAT_BUSY] = (state != RCMI_IDLE);
        next_prdata[HSTAT_READY] = link.res_n_out;
        next_prdata[HSTAT_DONE] = done;
      end
      default: next_err = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= '0;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end
    else
    begin
      pready <= 1'b1;
      if (setup)
      begin
        prdata <= next_prdata;
        pslverr <= next_err;
      end
    end
  end
endmodule // rcmi_host

/* File: dv/rcmi_chk.sv */
// Purpose: Concurrent checks on the link between host bridge and device.
// Assumes: One system clock; ext_res_n is the reset of the link side.
// Notes: Test mode is tracked from seen writes; scan mode is not visible here.
module rcmi_chk import rcmi_pkg::*; (
  input wire logic clk, // System clock
  input wire logic ext_res_n, // External reset, active low
  input wire logic res_n_out, // Synchronised reset
  input wire logic reg_wr, // Write pulse
  input wire logic reg_rd, // Read pulse
  input wire logic [REG_AW-1:0] reg_addr, // Byte offset
  input wire logic [DW-1:0] reg_wdata, // Write data
  input wire logic [DW-1:0] reg_rdata, // Read data
  input wire logic reg_rvalid // Read answer pulse
);
  logic tst_on;
  logic test_reg;
  assign test_reg = (reg_addr >= OFF_TCTL) && (reg_addr <= OFF_RDAT);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!ext_res_n);
  ////////////////////////////////////////////////////////////////////////////
  // Soft reset in the same write leaves test mode off
  always_ff @(posedge clk or negedge ext_res_n)
  begin
    if (!ext_res_n)
    begin
      tst_on <= 1'b0;
    end
    else if (reg_wr && reg_addr == OFF_MODE)
    begin
      tst_on <= reg_wdata[MODE_TEST_MODE_BIT] && !reg_wdata[MODE_SRST];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_release_slow: assert property ($rose(ext_res_n) |-> !res_n_out ##1 !res_n_out)
    else $error("reset output released too early");
  a_release_done: assert property ($rose(ext_res_n) ##1 ext_res_n [*2] |-> res_n_out)
    else $error("reset output not released after two edges");
  a_access_ready: assert property ((reg_wr || reg_rd) |-> res_n_out)
    else $error("access while device in reset");
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered next cycle");
  a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read answer without request");
  a_rdata_holds: assert property ($changed(reg_rdata) |-> reg_rvalid || reg_rdata == '0)
    else $error("read data changed without answer");
  a_write_space: assert property (reg_wr |=> !reg_wr [*2])
    else $error("writes closer than three cycles");
  a_test_gate: assert property (reg_rd && !tst_on && test_reg |=> reg_rdata == '0)
    else $error("test register readable outside test mode");
  a_srst_reads0: assert property (reg_rd && reg_addr == OFF_MODE |=> !reg_rdata[MODE_SRST])
    else $error("soft reset bit reads back set");
endmodule // rcmi_chk

/* File: dv/rcmi_tb.sv */
// Purpose: Self-checking bench driving host bridge and device over APB.
// Assumes: Bridge polls done before each new command.
// Notes: Only one technology target runs per build; ASIC gating chosen.
module rcmi_tb import rcmi_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [REG_AW-1:0] paddr = 8'h00;
  logic [DW-1:0] pwdata = 32'h0;
  logic [DW-1:0] prdata;
  logic pready;
  logic pslverr;
  logic scan_enable = 1'b0;
  logic can_rx = 1'b1;
  logic can_tx;
  logic rx_bit;
  int error_cnt = 0;
  int checked = 0;
  logic [31:0] seed = 32'h7332AEEC;
  bit m_tst;
  bit m_en;
  logic [31:0] m_dest;
  logic [31:0] m_wdat;
  logic [31:0] mem [int];
  bit mpar [int];
  logic [31:0] dq [$];
  always #5 pclk = ~pclk;
  rcmi_if rcmi_if_inst (.clk(pclk));
  rcmi_host rcmi_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(rcmi_if_inst.host));
  rcmi_device #(.TARGET_TECH(TARGET_ASIC), .TEST_REGS_EN(1'b1)) rcmi_device_inst (.link(rcmi_if_inst.dev),
    .scan_enable(scan_enable), .can_rx(can_rx), .can_tx(can_tx), .rx_bit(rx_bit));
  rcmi_chk rcmi_chk_inst (.clk(pclk), .ext_res_n(rcmi_if_inst.ext_res_n), .res_n_out(rcmi_if_inst.res_n_out),
    .reg_wr(rcmi_if_inst.reg_wr), .reg_rd(rcmi_if_inst.reg_rd), .reg_addr(rcmi_if_inst.reg_addr),
    .reg_wdata(rcmi_if_inst.reg_wdata), .reg_rdata(rcmi_if_inst.reg_rdata), .reg_rvalid(rcmi_if_inst.reg_rvalid));
  ////////////////////////////////////////////////////////////////////////////
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task print_verdict();
    if (error_cnt == 0 && checked > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask
  task cmp_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask
  task timeout();
    error_cnt++;
    $display("unexpected at %0t: wait ran out", $time);
    print_verdict();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      timeout();
    end
    r = prdata;
    cmp_bit(pslverr, a > H_STAT);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_stat(input int bitpos);
    logic [31:0] s;
    int n;
    n = 0;
    do
    begin
      apb(1'b0, H_STAT, 32'h0, s);
      n++;
    end
    while (!(s[bitpos] === 1'b1 && s[HSTAT_BUSY] === 1'b0) && n < 30);
    if (!(s[bitpos] === 1'b1 && s[HSTAT_BUSY] === 1'b0))
    begin
      timeout();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  function bit in_range(input logic [31:0] dst);
    return dst[17:16] == TGT_RX ? dst[11:0] < RX_DEPTH : dst[17:16] <= TXT_COUNT && dst[11:0] < TXT_DEPTH;
  endfunction
  function void mdl_clear();
    m_tst = 1'b0;
    m_en = 1'b0;
    m_dest = 32'h0;
    m_wdat = 32'h0;
  endfunction
  function void mdl_wr(input logic [7:0] a, input logic [31:0] d);
    if (a == OFF_MODE)
    begin
      m_tst = d[MODE_TEST_MODE_BIT];
      if (d[MODE_SRST] && !scan_enable)
      begin
        mdl_clear();
      end
    end
    else if (m_tst && a == OFF_TCTL)
    begin
      if (d[TCTL_WRSTB] && d[TCTL_MEMORY_TEST_ENABLE] && m_en && in_range(m_dest))
      begin
        mem[m_dest & 32'h0003_0FFF] = m_wdat;
        mpar[m_dest & 32'h0003_0FFF] = m_dest[DEST_PAR];
      end
      m_en = d[TCTL_MEMORY_TEST_ENABLE];
    end
    else if (m_tst && a == OFF_DEST)
    begin
      m_dest = d & DEST_MASK;
    end
    else if (m_tst && a == OFF_WDAT)
    begin
      m_wdat = d;
    end
  endfunction
  function logic [31:0] mdl_rd(input logic [7:0] a);
    if (a == OFF_MODE)
    begin
      return {30'h0, m_tst, 1'b0};
    end
    if (!m_tst)
    begin
      return 32'h0;
    end
    case (a)
      OFF_TCTL: return {31'h0, m_en};
      OFF_DEST: return m_dest;
      OFF_WDAT: return m_wdat;
      default: return in_range(m_dest) && mem.exists(m_dest & 32'h0003_0FFF) ? mem[m_dest & 32'h0003_0FFF] : 32'h0;
    endcase
  endfunction
  // Raw parity bit stored with the word at the current destination
  function logic mdl_par();
    return m_tst && in_range(m_dest) && mpar.exists(m_dest & 32'h0003_0FFF) ? mpar[m_dest & 32'h0003_0FFF] : 1'b0;
  endfunction
  task dev_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] s;
    apb(1'b1, H_WDAT, d, s);
    apb(1'b1, H_CMD, {23'h0, 1'b1, a}, s);
    wait_stat(HSTAT_DONE);
    apb(1'b1, H_STAT, 32'h4, s);
    mdl_wr(a, d);
  endtask
  // Status compares receive bit, stored parity and test access
  task chk(input logic [7:0] a);
    logic [31:0] r;
    apb(1'b1, H_CMD, {24'h0, a}, r);
    wait_stat(HSTAT_DONE);
    apb(1'b1, H_STAT, 32'h4, r);
    apb(1'b0, H_RDAT, 32'h0, r);
    if (a == OFF_STAT)
    begin
      cmp_bit(r[STAT_RXBIT], can_rx);
      cmp_bit(r[STAT_PAR], mdl_par());
      cmp_bit(r[STAT_TACC], m_tst);
    end
    else
    begin
      cmp_word(r, mdl_rd(a));
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] d;
    logic [31:0] r;
    mdl_clear();
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    wait_stat(HSTAT_READY);
    apb(1'b0, 8'h20, 32'h0, r);
    dev_wr(OFF_WDAT, 32'hA5A5_5A5A);
    chk(OFF_WDAT);
    dev_wr(OFF_MODE, 32'h2);
    chk(OFF_WDAT);
    chk(OFF_MODE);
    dev_wr(OFF_TCTL, 32'h1);
    for (int i = 0; i < 10; i++)
    begin
      d = rnd();
      d = {d[31], 13'h0, i[1:0] % 2'h3, 4'h0, i < 3 ? 12'h0 : i < 6 ? (i % 3 == 0 ? 12'h07F : 12'h013) : d[11:0] % 12'h014};
      d = i == 9 ? 32'h0001_0014 : d;
      dq.push_back(d);
      dev_wr(OFF_DEST, d);
      dev_wr(OFF_WDAT, rnd());
      dev_wr(OFF_TCTL, 32'h3);
    end
    chk(OFF_DEST);
    foreach (dq[i])
    begin
      dev_wr(OFF_DEST, dq[i]);
      chk(OFF_RDAT);
      chk(OFF_STAT);
    end
    dev_wr(OFF_DEST, dq[0]);
    dev_wr(OFF_TCTL, 32'h0);
    dev_wr(OFF_WDAT, rnd());
    dev_wr(OFF_TCTL, 32'h2);
    dev_wr(OFF_TCTL, 32'h3);
    chk(OFF_RDAT);
    chk(OFF_TCTL);
    for (int i = 0; i < 4; i++)
    begin
      d = rnd();
      @(posedge pclk);
      can_rx <= d[0];
      repeat (3) @(posedge pclk);
      #1;
      cmp_bit(rx_bit, can_rx);
      chk(OFF_STAT);
    end
    cmp_bit(can_tx, CAN_RECESSIVE);
    @(posedge pclk);
    scan_enable <= 1'b1;
    dev_wr(OFF_MODE, 32'h3);
    chk(OFF_MODE);
    @(posedge pclk);
    scan_enable <= 1'b0;
    dev_wr(OFF_MODE, 32'h2);
    dev_wr(OFF_MODE, 32'h3);
    chk(OFF_MODE);
    dev_wr(OFF_MODE, 32'h2);
    chk(OFF_WDAT);
    chk(OFF_RDAT);
    apb(1'b1, H_CTRL, 32'h1, r);
    repeat (3) @(posedge pclk);
    apb(1'b0, H_STAT, 32'h0, r);
    cmp_bit(r[HSTAT_READY], 1'b0);
    mdl_clear();
    apb(1'b1, H_CTRL, 32'h0, r);
    wait_stat(HSTAT_READY);
    chk(OFF_MODE);
    @(posedge pclk);
    presetn <= 1'b0;
    #2;
    cmp_bit(rcmi_if_inst.res_n_out, 1'b0);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    wait_stat(HSTAT_READY);
    chk(OFF_MODE);
    print_verdict();
  end
endmodule // rcmi_tb
